// ===== inc/ext_bus_pkg.sv
// Types and constants for the external bus control block
package ext_bus_pkg;

    localparam int ADDR_W = 24;
    localparam int DATA_W = 8;
    localparam int NUM_CS = 4;

    // Chip select windows: select active when (addr & mask) == base and the space matches CS_IO_SPACE
    localparam logic [23:0] CS_BASE [NUM_CS] = '{
        24'h000000, 24'h100000, 24'h200000, 24'h000000};
    localparam logic [23:0] CS_MASK [NUM_CS] = '{
        24'hf00000, 24'hf00000, 24'hf00000, 24'h0000f0};
    localparam logic [NUM_CS-1:0] CS_IO_SPACE = 4'h8;

    // Idle value of the strobe group after reset
    localparam logic [2:0] RST_STROBES = 3'h7;
    localparam logic [1:0] RST_REQS = 2'h3;

    typedef enum logic [1:0] {
        ACC_FETCH = 2'b00,
        ACC_READ  = 2'b01,
        ACC_WRITE = 2'b10
    } acc_kind_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ACC   = 2'b01,
        ST_GRANT = 2'b10
    } bus_state_t;

    // Request from the core
    typedef struct packed {
        logic             valid;
        logic             io_space;
        acc_kind_t        kind;
        logic [23:0]      addr;
        logic [7:0]       wdata;
    } core_req_t;

    // Registered bus pin image
    typedef struct packed {
        logic [23:0]      addr;
        logic [7:0]       wdata;
        logic             data_oe;
        logic             memory_request_n;
        logic             io_space_request_n;
        logic             rd_n;
        logic             wr_n;
        logic             opcode_fetch_indicator_n;
        logic [3:0]       cs_n;
    } pins_t;

    typedef struct packed {
        bus_state_t       state;
        pins_t            pins;
        logic             grant_n;
        logic             stopped_n;
        logic             nmi_pend;
        logic             done;
        logic [7:0]       rdata;
    } ctl_state_t;

endpackage

// ===== logic/ext_bus_ctl.sv
// External memory and I/O bus control with bus handover
`timescale 1ns/100ps

module ext_bus_ctl
    import ext_bus_pkg::*;
(
    // Clock and reset
    input  wire logic              CLK_SYS,
    input  wire logic              RST_N,
    // Core side
    input  wire core_req_t         CORE_REQ,
    output logic                   CORE_READY,
    output logic                   CORE_DONE,
    output logic [7:0]             CORE_RDATA,
    input  wire logic              INSTR_END,
    input  wire logic              HALT_EXEC,
    input  wire logic              SLEEP_INSTRUCTION,
    input  wire logic              WAKE,
    input  wire logic              MASKABLE_IRQ,
    input  wire logic              IRQ_ENABLE,
    output logic                   NMI_TAKE,
    output logic                   IRQ_TAKE,
    // Address bus
    input  wire logic [23:0]       ADDR_I,
    output logic [23:0]            ADDR_O,
    output logic                   ADDR_OE,
    // Data bus
    input  wire logic [7:0]        DATA_I,
    output logic [7:0]             DATA_O,
    output logic                   DATA_OE,
    // Requests, two-way
    input  wire logic              MEMORY_REQUEST_N_I,
    output logic                   MEMORY_REQUEST_N_O,
    input  wire logic              IO_SPACE_REQUEST_N_I,
    output logic                   IO_SPACE_REQUEST_N_O,
    output logic                   REQ_OE,
    // Strobes, three-state; chip selects always driven
    output logic                   RD_N,
    output logic                   WR_N,
    output logic                   OPCODE_FETCH_INDICATOR_N,
    output logic                   STROBE_OE,
    output logic                   CHIP_SELECT_ZERO_N,
    output logic                   CHIP_SELECT_ONE_N,
    output logic                   CHIP_SELECT_TWO_N,
    output logic                   CHIP_SELECT_THREE_N,
    // Handover and misc
    input  wire logic              WAIT_N,
    input  wire logic              BUS_RELEASE_REQUEST_N,
    output logic                   BUS_GRANT_N,
    input  wire logic              NMI_N,
    output logic                   STOPPED_STATE_N
);

    logic       rst_meta_q;
    logic       rst_sync_q;
    ctl_state_t s_q;
    ctl_state_t s_d;
    logic [3:0] cs_hit;
    logic [3:0] cs_ext;

    // Reset release through two stages; outside must hold RST_N long enough
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Address decode for selects, applied to a core address
    always_comb begin
        for (int i = 0; i < NUM_CS; i++) begin
            cs_hit[i] = ((CORE_REQ.addr & CS_MASK[i]) == CS_BASE[i]) &&
                        (CORE_REQ.io_space == CS_IO_SPACE[i]);
        end
    end

    // Selects also follow an outside master's cycles, decoded from inputs
    always_comb begin
        for (int i = 0; i < NUM_CS; i++) begin
            cs_ext[i] = ((ADDR_I & CS_MASK[i]) == CS_BASE[i]) &&
                        (CS_IO_SPACE[i] ? !IO_SPACE_REQUEST_N_I
                                        : !MEMORY_REQUEST_N_I);
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.done = 1'b0;
        // Wake on any interrupt or explicit wake
        if (!s_q.stopped_n && (WAKE || !NMI_N || MASKABLE_IRQ)) begin
            s_d.stopped_n = 1'b1;
        end
        if (HALT_EXEC || SLEEP_INSTRUCTION) begin
            s_d.stopped_n = 1'b0;
        end
        // Level latch, set while NMI_N is low; cleared at instruction end once NMI_N is high
        if (!NMI_N) begin
            s_d.nmi_pend = 1'b1;
        end else if (INSTR_END) begin
            s_d.nmi_pend = 1'b0;
        end
        unique case (s_q.state)
            ST_IDLE: begin
                if (!BUS_RELEASE_REQUEST_N) begin
                    // Float first, grant on the next edge
                    s_d.state = ST_GRANT;
                    s_d.pins.data_oe = 1'b0;
                end else if (CORE_REQ.valid) begin
                    s_d.state = ST_ACC;
                    s_d.pins.addr = CORE_REQ.addr;
                    s_d.pins.wdata = CORE_REQ.wdata;
                    s_d.pins.memory_request_n = CORE_REQ.io_space;
                    s_d.pins.io_space_request_n = !CORE_REQ.io_space;
                    s_d.pins.rd_n = (CORE_REQ.kind == ACC_WRITE);
                    s_d.pins.wr_n = (CORE_REQ.kind != ACC_WRITE);
                    s_d.pins.opcode_fetch_indicator_n =
                        !(CORE_REQ.kind == ACC_FETCH &&
                          !CORE_REQ.io_space);
                    s_d.pins.data_oe = (CORE_REQ.kind == ACC_WRITE);
                    s_d.pins.cs_n = ~cs_hit;
                end
            end
            ST_ACC: begin
                // Pins hold while wait is low
                if (WAIT_N) begin
                    s_d.state = ST_IDLE;
                    s_d.done = 1'b1;
                    s_d.rdata = DATA_I;
                    s_d.pins.memory_request_n = 1'b1;
                    s_d.pins.io_space_request_n = 1'b1;
                    s_d.pins.rd_n = 1'b1;
                    s_d.pins.wr_n = 1'b1;
                    s_d.pins.opcode_fetch_indicator_n = 1'b1;
                    s_d.pins.data_oe = 1'b0;
                    s_d.pins.cs_n = 4'hf;
                end
            end
            ST_GRANT: begin
                s_d.grant_n = 1'b0;
                s_d.pins.cs_n = ~cs_ext;
                if (BUS_RELEASE_REQUEST_N && !s_q.grant_n) begin
                    s_d.state = ST_IDLE;
                    s_d.grant_n = 1'b1;
                    s_d.pins.cs_n = 4'hf;
                end
            end
            default: s_d.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge CLK_SYS or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            s_q.state <= ST_IDLE;
            s_q.pins.addr <= '0;
            s_q.pins.wdata <= '0;
            s_q.pins.data_oe <= 1'b0;
            {s_q.pins.memory_request_n, s_q.pins.io_space_request_n}
                <= RST_REQS;
            {s_q.pins.rd_n, s_q.pins.wr_n,
             s_q.pins.opcode_fetch_indicator_n} <= RST_STROBES;
            s_q.pins.cs_n <= 4'hf;
            s_q.grant_n <= 1'b1;
            s_q.stopped_n <= 1'b1;
            s_q.nmi_pend <= 1'b0;
            s_q.done <= 1'b0;
            s_q.rdata <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // Nonmaskable wins over any maskable source, enables ignored
    assign NMI_TAKE   = INSTR_END && s_q.nmi_pend;
    assign IRQ_TAKE   = INSTR_END && !s_q.nmi_pend &&
                        MASKABLE_IRQ && IRQ_ENABLE;
    assign CORE_READY = (s_q.state == ST_IDLE) && BUS_RELEASE_REQUEST_N;
    assign CORE_DONE  = s_q.done;
    assign CORE_RDATA = s_q.rdata;

    // Driving only while the bus is ours, except the chip selects
    assign ADDR_OE   = (s_q.state != ST_GRANT);
    assign REQ_OE    = (s_q.state != ST_GRANT);
    assign STROBE_OE = (s_q.state != ST_GRANT);
    assign ADDR_O    = s_q.pins.addr;
    assign DATA_O    = s_q.pins.wdata;
    assign DATA_OE   = s_q.pins.data_oe && (s_q.state == ST_ACC);
    assign MEMORY_REQUEST_N_O       = s_q.pins.memory_request_n;
    assign IO_SPACE_REQUEST_N_O     = s_q.pins.io_space_request_n;
    assign RD_N                     = s_q.pins.rd_n;
    assign WR_N                     = s_q.pins.wr_n;
    assign OPCODE_FETCH_INDICATOR_N = s_q.pins.opcode_fetch_indicator_n;
    assign CHIP_SELECT_ZERO_N       = s_q.pins.cs_n[0];
    assign CHIP_SELECT_ONE_N        = s_q.pins.cs_n[1];
    assign CHIP_SELECT_TWO_N        = s_q.pins.cs_n[2];
    assign CHIP_SELECT_THREE_N      = s_q.pins.cs_n[3];
    assign BUS_GRANT_N              = s_q.grant_n;
    assign STOPPED_STATE_N          = s_q.stopped_n;

    sequence s_grant_req;
        (s_q.state == ST_IDLE) && !BUS_RELEASE_REQUEST_N;
    endsequence
    sequence s_floated_then_grant;
        !ADDR_OE && !STROBE_OE ##1 !BUS_GRANT_N;
    endsequence

    a_io_request: assert property (
        @(posedge CLK_SYS) disable iff (!rst_sync_q)
        (CORE_READY && CORE_REQ.valid && CORE_REQ.io_space)
        |=> !IO_SPACE_REQUEST_N_O && MEMORY_REQUEST_N_O && (RD_N != WR_N))
        else $error("io request malformed");

    a_mem_request: assert property (
        @(posedge CLK_SYS) disable iff (!rst_sync_q)
        (CORE_READY && CORE_REQ.valid && !CORE_REQ.io_space)
        |=> !MEMORY_REQUEST_N_O && IO_SPACE_REQUEST_N_O && (RD_N != WR_N))
        else $error("memory request missing");

    a_addr_input: assert property (
        @(posedge CLK_SYS) disable iff (!rst_sync_q)
        !BUS_GRANT_N |-> !ADDR_OE && !REQ_OE)
        else $error("address driven while granted");

    a_read_strobe: assert property (
        @(posedge CLK_SYS) disable iff (!rst_sync_q)
        (CORE_READY && CORE_REQ.valid && CORE_REQ.kind == ACC_READ)
        |=> !RD_N && WR_N)
        else $error("read strobe missing");

    a_write_strobe: assert property (
        @(posedge CLK_SYS) disable iff (!rst_sync_q)
        (CORE_READY && CORE_REQ.valid && CORE_REQ.kind == ACC_WRITE)
        |=> !WR_N && RD_N && DATA_OE)
        else $error("write strobe missing");

    a_fetch_ind: assert property (
        @(posedge CLK_SYS) disable iff (!rst_sync_q)
        !OPCODE_FETCH_INDICATOR_N |-> !MEMORY_REQUEST_N_O && !RD_N)
        else $error("fetch indicator alone");

    a_strobe_float: assert property (
        @(posedge CLK_SYS) disable iff (!rst_sync_q)
        !BUS_GRANT_N |-> !STROBE_OE)
        else $error("strobes driven");

    a_wait_hold: assert property (
        @(posedge CLK_SYS) disable iff (!rst_sync_q)
        (s_q.state == ST_ACC && !WAIT_N)
        |=> $stable(ADDR_O) && $stable(RD_N) && $stable(WR_N) && !CORE_DONE)
        else $error("wait ignored");

    a_grant_order: assert property (
        @(posedge CLK_SYS) disable iff (!rst_sync_q)
        s_grant_req |=> s_floated_then_grant)
        else $error("handover order wrong");

    a_grant_hold: assert property (
        @(posedge CLK_SYS) disable iff (!rst_sync_q)
        (!BUS_GRANT_N && !BUS_RELEASE_REQUEST_N) |=> !BUS_GRANT_N)
        else $error("grant left while requested");

    a_grant_release: assert property (
        @(posedge CLK_SYS) disable iff (!rst_sync_q)
        $rose(BUS_GRANT_N) |-> $past(BUS_RELEASE_REQUEST_N))
        else $error("grant dropped early");

    a_nmi_first: assert property (
        @(posedge CLK_SYS) disable iff (!rst_sync_q)
        NMI_TAKE |-> !IRQ_TAKE)
        else $error("nmi lost priority");

    a_stop_ind: assert property (
        @(posedge CLK_SYS) disable iff (!rst_sync_q)
        (HALT_EXEC || SLEEP_INSTRUCTION) |=> !STOPPED_STATE_N)
        else $error("stop not shown");

    a_data_only_wr: assert property (
        @(posedge CLK_SYS) disable iff (!rst_sync_q)
        DATA_OE |-> !WR_N && BUS_GRANT_N)
        else $error("data driven");

endmodule

// ===== dv/ext_bus_mem.sv
// Slow memory and peripheral model on the far side of the bus
`timescale 1ns/100ps
module ext_bus_mem
(
    // Bus as seen at the pins
    input  wire logic        clk,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [23:0] addr,
    input  wire logic [3:0]  wait_cycles,
    // Answers
    output logic             wait_n,
    output logic [7:0]       rdata
);
    logic [3:0] cnt;

    initial begin
        wait_n = 1'b1;
        rdata = 8'h00;
        cnt = 4'h0;
    end

    always @(posedge clk) begin
        #1;
        if (!rd_n || !wr_n) begin
            wait_n = (cnt >= wait_cycles);
            if (cnt < wait_cycles)
                cnt = cnt + 4'h1;
        end else begin
            wait_n = 1'b1;
            cnt = 4'h0;
        end
        // Released lines flip so a stale byte never looks valid
        rdata = !rd_n ? addr[7:0] ^ 8'h5a : ~rdata;
    end
endmodule

// ===== dv/testbench.sv
// Self-checking bench for the external bus control block
`timescale 1ns/100ps
module testbench;
    import ext_bus_pkg::*;

    logic        clk, rst_n, rdy, done, nmi_t, irq_t, instr_end, halt, sleep_instruction;
    logic        wake, mirq, irq_en, addr_oe, data_oe, req_oe, strobe_oe;
    logic        memory_request_n_o, ioreq_o, rd_n, wr_n, fetch_n, wait_n, brq_n, nmi_n;
    logic        grant_n, stop_n, ext_memory_request_n_n, io;
    logic [23:0] addr_o, ext_addr;
    logic [7:0]  rdata, data_o, mem_data;
    logic [3:0]  wcyc;
    wire  [3:0]  cs_n;
    logic [8:0]  ev;
    logic [8:0]  expq[$];
    core_req_t   req;
    int          err_total, comparisons, n, i;

    // Pin levels from whichever party drives; pull-ups on strobes
    wire logic [23:0] addr_w = addr_oe ? addr_o : ext_addr;
    wire logic [7:0]  data_w = data_oe ? data_o : mem_data;
    wire logic        memory_request_n_w = req_oe ? memory_request_n_o : ext_memory_request_n_n;
    wire logic        io_space_request_n_w = req_oe ? ioreq_o : 1'b1;
    wire logic        rd_w   = strobe_oe ? rd_n : 1'b1;
    wire logic        wr_w   = strobe_oe ? wr_n : 1'b1;

    ext_bus_ctl ext_bus_ctl_inst (
        .CLK_SYS(clk), .RST_N(rst_n), .CORE_REQ(req), .CORE_READY(rdy),
        .CORE_DONE(done), .CORE_RDATA(rdata), .INSTR_END(instr_end),
        .HALT_EXEC(halt), .SLEEP_INSTRUCTION(sleep_instruction), .WAKE(wake),
        .MASKABLE_IRQ(mirq), .IRQ_ENABLE(irq_en), .NMI_TAKE(nmi_t),
        .IRQ_TAKE(irq_t), .ADDR_I(addr_w), .ADDR_O(addr_o),
        .ADDR_OE(addr_oe), .DATA_I(data_w), .DATA_O(data_o),
        .DATA_OE(data_oe), .MEMORY_REQUEST_N_I(memory_request_n_w),
        .MEMORY_REQUEST_N_O(memory_request_n_o), .IO_SPACE_REQUEST_N_I(io_space_request_n_w),
        .IO_SPACE_REQUEST_N_O(ioreq_o), .REQ_OE(req_oe), .RD_N(rd_n),
        .WR_N(wr_n), .OPCODE_FETCH_INDICATOR_N(fetch_n),
        .STROBE_OE(strobe_oe), .CHIP_SELECT_ZERO_N(cs_n[0]),
        .CHIP_SELECT_ONE_N(cs_n[1]), .CHIP_SELECT_TWO_N(cs_n[2]),
        .CHIP_SELECT_THREE_N(cs_n[3]), .WAIT_N(wait_n),
        .BUS_RELEASE_REQUEST_N(brq_n), .BUS_GRANT_N(grant_n),
        .NMI_N(nmi_n), .STOPPED_STATE_N(stop_n));

    ext_bus_mem ext_bus_mem_inst (
        .clk(clk), .rd_n(rd_w), .wr_n(wr_w), .addr(addr_w),
        .wait_cycles(wcyc), .wait_n(wait_n), .rdata(mem_data));

    function automatic logic [3:0] cs_exp(logic sp, logic [23:0] a);
        for (int k = 0; k < NUM_CS; k++)
            cs_exp[k] = !(((a & CS_MASK[k]) == CS_BASE[k])
                          && sp == CS_IO_SPACE[k]);
    endfunction

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic give_verdict();
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic tmo(string nm);
        err_total++;
        $display("mismatch %s expected answer seen none", nm);
        give_verdict();
    endtask

    task automatic tick(int c);
        repeat (c) @(posedge clk);
        #1;
    endtask

    task automatic access(logic sp, acc_kind_t k, logic [23:0] a);
        logic [9:0] pins;
        int w;
        pins = {sp, !sp, k == ACC_WRITE, k != ACC_WRITE, k != ACC_FETCH,
                k == ACC_WRITE, cs_exp(sp, a)};
        req = '{1'b1, sp, k, a, 8'($urandom)};
        w = 0;
        @(negedge clk);
        while (rdy !== 1'b1) begin
            if (++w > 20)
                tmo("ready");
            @(negedge clk);
        end
        expq.push_back({k != ACC_WRITE, a[7:0] ^ 8'h5a});
        tick(1);
        req.valid = 1'b0;
        for (w = 0; w < 40; w++) begin
            @(negedge clk);
            if (done === 1'b1)
                break;
            chk("strobes", pins, {memory_request_n_o, ioreq_o, rd_n, wr_n, fetch_n, data_oe, cs_n});
            chk("address", a, addr_o);
            if (k == ACC_WRITE)
                chk("write data", req.wdata, data_o);
        end
        if (w == 40)
            tmo("done");
        chk("wait cycles", wcyc + 1, w);
        chk("strobes idle", 3'h7, {rd_n, wr_n, fetch_n});
        tick(1);
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Result watcher pairs each finished access with the oldest note
    always @(negedge clk) begin
        if (done === 1'b1) begin
            if (expq.size() == 0)
                chk("done", 0, 1);
            else begin
                ev = expq.pop_front();
                if (ev[8])
                    chk("read data", ev[7:0], rdata);
            end
        end
    end

    initial begin
        {rst_n, instr_end, halt, sleep_instruction, wake, mirq, irq_en} = '0;
        {brq_n, nmi_n, ext_memory_request_n_n} = 3'h7;
        req = '0;
        wcyc = '0;
        ext_addr = '0;
        err_total = 0;
        comparisons = 0;
        void'($urandom(70544));
        repeat (10) @(negedge clk);
        chk("reset pins", 15'h7ffe, {rd_n, wr_n, fetch_n, memory_request_n_o, ioreq_o, grant_n, stop_n, cs_n, addr_oe, req_oe, strobe_oe, data_oe});
        repeat (10) @(posedge clk);
        #1;
        rst_n = 1'b1;
        tick(3);
        for (n = 0; n < 30; n++) begin
            wcyc = (n < 3) ? 4'(n * 3) : 4'($urandom_range(3, 0));
            i = n % 3;
            io = (i != 0) && n[2];
            access(io, acc_kind_t'(i), io ? {16'h0, 8'($urandom_range(31, 0))}
                   : {4'($urandom_range(3, 0)), 20'($urandom)});
        end
        brq_n = 1'b0;
        for (i = 0; grant_n !== 1'b0; i++) begin
            if (i > 5)
                tmo("grant");
            tick(1);
        end
        ext_addr = 24'h100000;
        ext_memory_request_n_n = 1'b0;
        req = '{1'b1, 1'b0, ACC_READ, 24'h0, 8'h0};
        for (i = 0; i < 4; i++) begin
            @(negedge clk);
            chk("granted", 6'h0, {addr_oe, req_oe, strobe_oe, data_oe, rdy, grant_n});
        end
        chk("granted select", cs_exp(1'b0, ext_addr), cs_n);
        tick(1);
        req.valid = 1'b0;
        brq_n = 1'b1;
        ext_memory_request_n_n = 1'b1;
        tick(1);
        chk("released", 4'hf, {addr_oe, req_oe, strobe_oe, grant_n});
        mirq = 1'b1;
        for (n = 0; n < 4; n++) begin
            nmi_n = !(n < 2);
            irq_en = n[0];
            tick(1);
            nmi_n = 1'b1;
            @(negedge clk);
            chk("no take", 2'h0, {nmi_t, irq_t});
            tick(1);
            instr_end = 1'b1;
            @(negedge clk);
            chk("take", {n < 2, n == 3}, {nmi_t, irq_t});
            tick(1);
            instr_end = 1'b0;
        end
        // A standing interrupt would wake at once and hide the wake input
        mirq = 1'b0;
        for (n = 0; n < 2; n++) begin
            halt = (n == 0);
            sleep_instruction = (n == 1);
            tick(1);
            halt = 1'b0;
            sleep_instruction = 1'b0;
            chk("stopped", 1'b0, stop_n);
            tick(1);
            chk("still stopped", 1'b0, stop_n);
            wake = 1'b1;
            tick(1);
            wake = 1'b0;
            chk("woken", 1'b1, stop_n);
        end
        tick(2);
        chk("queue empty", 0, expq.size());
        give_verdict();
    end
endmodule
